/* File: irqrh_pkg.sv */
// Purpose: shared constants and types of the interrupt request handler
// Assumes: apb byte address is four times the register index
// Notes:   ic registers sit at indices 0x50..0x57, timer a0 at 0x55
`default_nettype none
package irqrh_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NSRC   = 8;
  localparam int ADDR_W = 12;

  // ----------------------------------------------------------------
  // register indices (byte address = index * 4)
  // ----------------------------------------------------------------
  localparam logic [9:0] IDX_ACK     = 10'h000;
  localparam logic [9:0] IDX_IC_BASE = 10'h050;
  localparam logic [9:0] IDX_TIMER_A0_IRQ_CONTROL   = 10'h055;
  localparam logic [9:0] IDX_PORT8   = 10'h0f0;
  localparam logic [9:0] IDX_SYSCTL  = 10'h100;
  localparam logic [9:0] IDX_SP      = 10'h101;
  localparam logic [9:0] IDX_STS     = 10'h102;
  localparam logic [9:0] IDX_MSK     = 10'h103;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int IC_LVL_LSB   = 0;
  localparam int IC_REQ_BIT   = 3;
  localparam int IC_POL_BIT   = 4;
  localparam int P8_NMI_BIT   = 5;
  localparam int CTL_STOP_BIT = 0;
  localparam int CTL_WAIT_BIT = 1;
  localparam int EV_NMI       = 0;
  localparam int EV_SWACK     = 1;
  localparam int EV_STOPREF   = 2;
  localparam int ACK_VLD_BIT  = 7;
  localparam int ACK_LVL_LSB  = 4;
  localparam int NUM_PINS     = 2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  IC_RST   = 8'h00;
  localparam logic [15:0] SP_RST   = 16'h0000;
  localparam logic [2:0]  MSK_RST  = 3'h0;
  localparam logic [2:0]  SYNC_RST = 3'h4;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       strobe;
    logic       valid;
    logic [2:0] num;
    logic [2:0] lvl;
  } irqrh_ack_t;

  typedef struct packed {
    logic [NSRC-1:0][7:0] ic;
    logic [1:0]           pin_eff;
    logic                 nmi_lvl;
    logic                 nmi_pend;
    logic                 stop;
    logic                 wait_m;
    logic                 halt;
    logic [15:0]          sp;
    logic [2:0]           sts;
    logic [2:0]           msk;
    logic                 irq;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    irqrh_ack_t           ack;
  } irqrh_state_t;

endpackage
`default_nettype wire

/* File: irqrh_sync.sv */
// Purpose: two-flop synchroniser for asynchronous pins
// Assumes: one destination clock
// Notes:   first stage is read only by the second
`default_nettype none
`timescale 1ns/1ps
module irqrh_sync #(
  parameter int              WIDTH = 3,
  parameter logic [WIDTH-1:0] RST  = '0
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q <= RST;
      q      <= RST;
    end
    else
    begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule
`default_nettype wire

/* File: irqrh_ctrl.sv */
// Purpose: interrupt request handler with apb registers and cpu ack port
// Assumes: pins are asynchronous, cpu strobes are on pclk
// Notes:   one wait state on every apb access
//
// Behaviour
// [R1] ack presents number and level to cpu
// [R2] ack clears the supplied request bit
// [R3] any read of ack address clears too
// [R4] software must never read ack address
// [R5] stack pointer resets to zero
// [R6] software loads stack pointer before interrupts
// [R7] nmi cannot be disabled
// [R8] nmi pin readable as port bit
// [R9] stop request forced zero while nmi low
// [R10] wait with nmi low keeps oscillator running
// [R11] nmi levels held two clocks plus 300ns
// [R12] polarity change may set request bit
// [R13] software clears request after polarity change
// [R14] software restarts watchdog after its interrupt
// [R15] rewrite control register only with interrupts off
// [R16] writing zero clears level and request
// [R17] software waits before re-enabling interrupts
// [R18] request during rewrite is preserved
// [R19] highest nonzero level pending source selected
//
// Chosen here: the APB interface to the registers.
`default_nettype none
`timescale 1ns/1ps
module irqrh_ctrl (
  // clock and reset
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  // apb slave
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [irqrh_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  // pins
  input  wire logic                         nmi_n_pin,
  input  wire logic [1:0]                   ext_request_pins,
  // on-chip request sources
  input  wire logic [irqrh_pkg::NSRC-1:0]   irq_src,
  // cpu core
  input  wire logic                         cpu_ack_req,
  input  wire logic                         cpu_nmi_ack,
  output irqrh_pkg::irqrh_ack_t             cpu_ack,
  output logic                              nmi_req,
  output logic                              cpu_halt,
  output logic                              osc_stop,
  output logic      [15:0]                  stack_ptr,
  // interrupt to system
  output logic                              irq
);
  import irqrh_pkg::*;

  irqrh_state_t     s_q;
  irqrh_state_t     s_d;
  logic [2:0]       sync_q;
  logic             nmi_s;
  logic [NSRC-1:0]  evt;
  logic [1:0]       eff;
  irqrh_ack_t       sel;
  logic [9:0]       idx;
  logic             prep;
  logic             wr;
  logic             rd;
  logic             ic_hit;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  irqrh_sync #(
    .WIDTH (3),
    .RST   (SYNC_RST)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({nmi_n_pin, ext_request_pins}),
    .q       (sync_q)
  );
  assign nmi_s = sync_q[2];

  // ----------------------------------------------------------------
  // per-source request events
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NSRC; i++)
  begin : g_evt
    if (i < NUM_PINS)
    begin : g_pin
      // polarity flip changes eff and can raise a request
      assign eff[i] = sync_q[i] ^ s_q.ic[i][IC_POL_BIT]; // R12
      assign evt[i] = eff[i] & ~s_q.pin_eff[i]; // R12
    end
    else
    begin : g_int
      assign evt[i] = irq_src[i];
    end
  end

  // ----------------------------------------------------------------
  // priority selection
  // ----------------------------------------------------------------
  function automatic irqrh_ack_t pick(input logic [NSRC-1:0][7:0] ic);
    irqrh_ack_t r;
    r = '0;
    for (int i = 0; i < NSRC; i++)
    begin
      if (ic[i][IC_REQ_BIT] && (ic[i][2:0] > r.lvl))
      begin
        r.valid = 1'b1;
        r.num   = 3'(i);
        r.lvl   = ic[i][2:0];
      end
    end
    return r;
  endfunction

  assign sel    = pick(s_q.ic); // R19
  assign idx    = paddr[11:2];
  assign prep   = psel & penable & ~s_q.pready;
  assign wr     = psel & penable & s_q.pready & pwrite;
  assign rd     = psel & penable & s_q.pready & ~pwrite;
  assign ic_hit = (idx[9:3] == IDX_IC_BASE[9:3]);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [2:0] ev;
    logic       wake;
    ev   = '0;
    s_d  = s_q;
    wake = sel.valid | s_q.nmi_pend;
    // apb read data and answer
    s_d.pready  = prep;
    s_d.pslverr = 1'b0;
    if (prep)
    begin
      s_d.prdata = '0;
      if (ic_hit)
        s_d.prdata[7:0] = s_q.ic[idx[2:0]];
      else if (idx == IDX_ACK)
        s_d.prdata[7:0] = {sel.valid, sel.lvl, 1'b0, sel.num};
      else if (idx == IDX_PORT8)
        s_d.prdata[P8_NMI_BIT] = nmi_s; // R8
      else if (idx == IDX_SYSCTL)
        s_d.prdata[1:0] = {s_q.wait_m, s_q.stop};
      else if (idx == IDX_SP)
        s_d.prdata[15:0] = s_q.sp;
      else if (idx == IDX_STS)
        s_d.prdata[2:0] = s_q.sts;
      else if (idx == IDX_MSK)
        s_d.prdata[2:0] = s_q.msk;
      else
        s_d.pslverr = 1'b1;
    end
    if (rd && idx == IDX_ACK)
      ev[EV_SWACK] = 1'b1; // R4
    // request bits
    for (int i = 0; i < NSRC; i++)
    begin
      if (wr && ic_hit && idx[2:0] == 3'(i))
        s_d.ic[i] = {3'h0, pwdata[4:0]}; // R16
      if (cpu_ack_req && sel.valid && sel.num == 3'(i))
        s_d.ic[i][IC_REQ_BIT] = 1'b0; // R2
      if (rd && idx == IDX_ACK && s_q.prdata[ACK_VLD_BIT]
          && s_q.prdata[2:0] == 3'(i))
        s_d.ic[i][IC_REQ_BIT] = 1'b0; // R3
      if (evt[i])
        s_d.ic[i][IC_REQ_BIT] = 1'b1; // R18
    end
    s_d.pin_eff = eff;
    // cpu acknowledge
    s_d.ack.strobe = cpu_ack_req;
    if (cpu_ack_req)
    begin
      s_d.ack.valid = sel.valid; // R1
      s_d.ack.num   = sel.num; // R1
      s_d.ack.lvl   = sel.lvl; // R1
    end
    // nmi: falling edge, no enable gates it
    s_d.nmi_lvl = nmi_s;
    if (cpu_nmi_ack)
      s_d.nmi_pend = 1'b0;
    if (s_q.nmi_lvl && !nmi_s)
    begin
      s_d.nmi_pend = 1'b1; // R7
      ev[EV_NMI]   = 1'b1;
    end
    // power modes
    if (wr && idx == IDX_SYSCTL)
    begin
      s_d.stop   = pwdata[CTL_STOP_BIT] & nmi_s; // R9
      s_d.wait_m = pwdata[CTL_WAIT_BIT]; // R10
      s_d.halt   = (pwdata[CTL_STOP_BIT] & nmi_s) | pwdata[CTL_WAIT_BIT]; // R9
      if (pwdata[CTL_STOP_BIT] && !nmi_s)
        ev[EV_STOPREF] = 1'b1;
    end
    else if (wake && s_q.halt)
    begin
      s_d.halt   = 1'b0; // R10
      s_d.stop   = 1'b0;
      s_d.wait_m = 1'b0;
    end
    if (!nmi_s)
      s_d.stop = 1'b0; // R9
    // stack pointer, status, mask
    if (wr && idx == IDX_SP)
      s_d.sp = pwdata[15:0];
    if (wr && idx == IDX_MSK)
      s_d.msk = pwdata[2:0];
    if (wr && idx == IDX_STS)
      s_d.sts = s_q.sts & ~pwdata[2:0];
    s_d.sts = s_d.sts | ev;
    s_d.irq = |(s_d.sts & s_d.msk);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q         <= '0;
      s_q.ic      <= {NSRC{IC_RST}};
      s_q.nmi_lvl <= 1'b1;
      s_q.sp      <= SP_RST; // R5
      s_q.msk     <= MSK_RST;
    end
    else
      s_q <= s_d;
  end

  assign prdata    = s_q.prdata;
  assign pready    = s_q.pready;
  assign pslverr   = s_q.pslverr;
  assign cpu_ack   = s_q.ack;
  assign nmi_req   = s_q.nmi_pend;
  assign cpu_halt  = s_q.halt;
  assign osc_stop  = s_q.stop;
  assign stack_ptr = s_q.sp;
  assign irq       = s_q.irq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_ack_taken;
    cpu_ack_req && sel.valid;
  endsequence

  sequence s_swack_done;
    rd && idx == IDX_ACK && s_q.prdata[ACK_VLD_BIT];
  endsequence

  property p_ack_info;
    s_ack_taken |=> s_q.ack.strobe && s_q.ack.valid
      && s_q.ack.num == $past(sel.num) && s_q.ack.lvl == $past(sel.lvl);
  endproperty
  a_ack_info: assert property (p_ack_info) // R1
    else $error("ack info wrong");

  property p_ack_clear;
    s_ack_taken ##0 !evt[sel.num] |=> !s_q.ic[$past(sel.num)][IC_REQ_BIT];
  endproperty
  a_ack_clear: assert property (p_ack_clear) // R2
    else $error("ack did not clear request");

  property p_swack_clear;
    s_swack_done ##0 !evt[s_q.prdata[2:0]]
      |=> !s_q.ic[$past(s_q.prdata[2:0])][IC_REQ_BIT]
          && s_q.sts[EV_SWACK];
  endproperty
  a_swack_clear: assert property (p_swack_clear) // R3
    else $error("read of ack address did not clear");

  property p_nmi_nomask;
    s_q.nmi_lvl && !nmi_s |=> nmi_req ##1 (nmi_req || $past(cpu_nmi_ack));
  endproperty
  a_nmi_nomask: assert property (p_nmi_nomask) // R7
    else $error("nmi edge lost");

  property p_port8;
    prep && idx == IDX_PORT8 |=> s_q.prdata[P8_NMI_BIT] == $past(nmi_s);
  endproperty
  a_port8: assert property (p_port8) // R8
    else $error("port bit does not follow nmi");

  property p_stop_forced;
    !nmi_s |=> !s_q.stop;
  endproperty
  a_stop_forced: assert property (p_stop_forced) // R9
    else $error("stop set while nmi low");

  property p_wait_osc;
    wr && idx == IDX_SYSCTL && pwdata[CTL_WAIT_BIT] && !nmi_s
      |=> s_q.halt && !s_q.stop;
  endproperty
  a_wait_osc: assert property (p_wait_osc) // R10
    else $error("wait with nmi low stopped oscillator");

  property p_wake;
    s_q.halt && s_q.nmi_pend && !wr |=> !s_q.halt;
  endproperty
  a_wake: assert property (p_wake) // R10
    else $error("halt not left on interrupt");

  property p_zero_clear;
    wr && ic_hit && pwdata[7:0] == 8'h00 && !evt[idx[2:0]]
      |=> s_q.ic[$past(idx[2:0])] == 8'h00;
  endproperty
  a_zero_clear: assert property (p_zero_clear) // R16
    else $error("zero write left bits set");

  property p_set_wins;
    evt[5] |=> s_q.ic[5][IC_REQ_BIT];
  endproperty
  a_set_wins: assert property (p_set_wins) // R18
    else $error("request lost during rewrite");

  property p_sp_reset;
    $rose(presetn) |-> s_q.sp == SP_RST;
  endproperty
  a_sp_reset: assert property (p_sp_reset) // R5
    else $error("stack pointer not zero after reset");

endmodule
`default_nettype wire

/* File: irqrh_cpu_model.sv */
// Purpose: cpu core stand-in driving the acknowledge strobes
// Assumes: ack_go is a one-cycle pulse from the bench
// Notes:   a pending nmi is taken at once, one pulse per request
`default_nettype none
`timescale 1ns/1ps
module irqrh_cpu_model (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // bench side
  input  wire logic ack_go,
  // design side
  input  wire logic nmi_req,
  output logic      cpu_ack_req,
  output logic      cpu_nmi_ack
);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cpu_ack_req <= 1'b0;
      cpu_nmi_ack <= 1'b0;
    end
    else
    begin
      cpu_ack_req <= ack_go;
      // low again after one cycle so one nmi is taken once
      cpu_nmi_ack <= nmi_req & ~cpu_nmi_ack;
    end
  end
endmodule
`default_nettype wire

/* File: irq_request_handling_tb_top.sv */
// Purpose: self-checking bench of the request handler
// Assumes: one wait state per apb access
// Notes:   cpu core is a partner model
`default_nettype none
`timescale 1ns/1ps
module irq_request_handling_tb_top;
  import irqrh_pkg::*;
  logic                   pclk, presetn, psel, penable, pwrite, ack_go;
  logic                   pready, pslverr, nmi_n_pin, cpu_ack_req;
  logic                   cpu_nmi_ack, nmi_req, cpu_halt, osc_stop, irq;
  logic                   rerr;
  logic [ADDR_W-1:0]      paddr;
  logic [31:0]            pwdata, prdata, rdat;
  logic [1:0]             ext_pins;
  logic [NSRC-1:0]        irq_src;
  logic [15:0]            stack_ptr;
  irqrh_ack_t             cpu_ack;
  int                     error_cnt, total_checks, cyc, nmi_cnt;

  always #4 pclk = ~pclk;

  irqrh_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .nmi_n_pin(nmi_n_pin), .ext_request_pins(ext_pins),
    .irq_src(irq_src), .cpu_ack_req(cpu_ack_req),
    .cpu_nmi_ack(cpu_nmi_ack), .cpu_ack(cpu_ack), .nmi_req(nmi_req),
    .cpu_halt(cpu_halt), .osc_stop(osc_stop), .stack_ptr(stack_ptr),
    .irq(irq));

  irqrh_cpu_model cpu_u (.pclk(pclk), .presetn(presetn), .ack_go(ack_go),
    .nmi_req(nmi_req), .cpu_ack_req(cpu_ack_req),
    .cpu_nmi_ack(cpu_nmi_ack));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got_v, input logic [31:0] exp_v);
    total_checks++;
    if (got_v !== exp_v)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got_v, exp_v);
    end
  endtask

  task automatic apb(input logic w, input logic [9:0] ix,
                     input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {ix, 2'b00};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rdat    = prdata;
    rerr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [9:0] ix);
    apb(1'b0, ix, 32'h0);
  endtask

  task automatic wr(input logic [9:0] ix, input logic [31:0] wd);
    apb(1'b1, ix, wd);
  endtask

  task automatic pulse(input int i);
    @(posedge pclk);
    irq_src[i] <= 1'b1;
    @(posedge pclk);
    irq_src <= '0;
  endtask

  task automatic ack(input logic [6:0] exp_v, input logic full);
    @(posedge pclk);
    ack_go <= 1'b1;
    @(posedge pclk);
    ack_go <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(32'(cpu_ack.strobe), 32'h1);
    repeat (3) @(posedge pclk);
    if (full)
      chk(32'({cpu_ack.valid, cpu_ack.num, cpu_ack.lvl}), 32'(exp_v));
    else
      chk(32'(cpu_ack.valid), 32'h0);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk(32'(stack_ptr), 32'h0);
    rd(IDX_SP);
    chk(rdat, 32'h0);
    wr(IDX_SP, 32'h1234);
    rd(IDX_SP);
    chk(32'(stack_ptr), 32'h1234);
    $display("test reset done");
  endtask

  task automatic t_ack();
    wr(IDX_IC_BASE + 10'h5, 32'h3);
    wr(IDX_IC_BASE + 10'h6, 32'h5);
    wr(IDX_IC_BASE + 10'h7, 32'h5);
    repeat (2) @(posedge pclk);
    pulse(5);
    pulse(6);
    pulse(7);
    ack(7'h75, 1'b1);
    rd(IDX_IC_BASE + 10'h6);
    chk(rdat, 32'h5);
    ack(7'h7d, 1'b1);
    ack(7'h6b, 1'b1);
    ack(7'h00, 1'b0);
    $display("test ack done");
  endtask

  task automatic t_swread();
    pulse(7);
    rd(IDX_ACK);
    chk(rdat, 32'hd7);
    rd(IDX_IC_BASE + 10'h7);
    chk(rdat, 32'h5);
    rd(IDX_STS);
    chk(rdat, 32'h2);
    wr(IDX_STS, 32'h2);
    for (int i = 5; i < 8; i++)
      wr(IDX_IC_BASE + 10'(i), 32'h0);
    $display("test software read done");
  endtask

  task automatic t_nmi();
    rd(IDX_PORT8);
    chk(32'(rdat[P8_NMI_BIT]), 32'h1);
    nmi_n_pin <= 1'b0;
    repeat (40) @(posedge pclk);
    chk(32'(nmi_cnt), 32'h1);
    rd(IDX_PORT8);
    chk(32'(rdat[P8_NMI_BIT]), 32'h0);
    chk(32'(irq), 32'h0);
    wr(IDX_SYSCTL, 32'h1);
    repeat (2) @(posedge pclk);
    chk(32'(osc_stop), 32'h0);
    chk(32'(cpu_halt), 32'h0);
    rd(IDX_STS);
    chk(rdat, 32'h5);
    wr(IDX_MSK, 32'h1);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h1);
    wr(IDX_STS, 32'h7);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h0);
    $display("test nmi done");
  endtask

  task automatic t_power();
    wr(IDX_IC_BASE + 10'h5, 32'h1);
    wr(IDX_SYSCTL, 32'h2);
    repeat (2) @(posedge pclk);
    chk(32'({cpu_halt, osc_stop}), 32'h2);
    pulse(5);
    repeat (2) @(posedge pclk);
    chk(32'(cpu_halt), 32'h0);
    rd(IDX_IC_BASE + 10'h5);
    chk(rdat, 32'h9);
    wr(IDX_IC_BASE + 10'h5, 32'h0);
    rd(IDX_IC_BASE + 10'h5);
    chk(rdat, 32'h0);
    nmi_n_pin <= 1'b1;
    repeat (40) @(posedge pclk);
    wr(IDX_IC_BASE + 10'h5, 32'h2);
    wr(IDX_SYSCTL, 32'h1);
    repeat (2) @(posedge pclk);
    chk(32'({cpu_halt, osc_stop}), 32'h3);
    pulse(5);
    repeat (2) @(posedge pclk);
    chk(32'({cpu_halt, osc_stop}), 32'h0);
    wr(IDX_IC_BASE + 10'h5, 32'h0);
    $display("test power done");
  endtask

  task automatic t_pol();
    wr(IDX_IC_BASE, 32'h11);
    rd(IDX_IC_BASE);
    chk(rdat, 32'h19);
    wr(IDX_IC_BASE, 32'h11);
    rd(IDX_IC_BASE);
    chk(rdat, 32'h11);
    wr(IDX_IC_BASE + 10'h1, 32'h1);
    ext_pins[1] <= 1'b1;
    repeat (5) @(posedge pclk);
    rd(IDX_IC_BASE + 10'h1);
    chk(rdat, 32'h9);
    wr(IDX_IC_BASE, 32'h0);
    wr(IDX_IC_BASE + 10'h1, 32'h0);
    $display("test polarity done");
  endtask

  task automatic t_rewrite();
    @(posedge pclk);
    irq_src[6] <= 1'b1;
    wr(IDX_IC_BASE + 10'h6, 32'h2);
    irq_src <= '0;
    rd(IDX_IC_BASE + 10'h6);
    chk(rdat, 32'ha);
    wr(IDX_IC_BASE + 10'h6, 32'h0);
    rd(10'h3ff);
    chk(32'(rerr), 32'h1);
    wr(10'h3fe, 32'hffff_ffff);
    chk(32'(rerr), 32'h1);
    rd(IDX_SP);
    chk(rdat, 32'h1234);
    $display("test rewrite and unmapped done");
  endtask

  always @(posedge pclk)
  begin
    cyc++;
    if (cpu_nmi_ack === 1'b1)
      nmi_cnt++;
    if (cyc == 5000)
    begin
      error_cnt++;
      final_report();
    end
  end

  initial
  begin
    pclk      = 1'b0;
    presetn   = 1'b0;
    {psel, penable, pwrite, ack_go} = 4'h0;
    paddr     = '0;
    pwdata    = 32'h0;
    nmi_n_pin = 1'b1;
    ext_pins  = 2'h0;
    irq_src   = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    t_reset();
    t_ack();
    t_swread();
    t_nmi();
    t_power();
    t_pol();
    t_rewrite();
    final_report();
  end
endmodule
`default_nettype wire
